// File: core/protection_monitor_config.sv
/*
  Protection monitor configuration bank with a classic Wishbone slave.
  Holds drain-source thresholds, offline diagnostic enables and supply
  monitor settings, and runs the supply and charge-pump fault handling.
  Assumes comparator inputs synchronous to clk_i and a 200 MHz clock.
*/
`timescale 1ns/100ps
`include "protection_monitor_defs.svh"
module protection_monitor_config #(
  parameter int ADDR_W = 8,
  parameter int DG_W   = 11
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  input  wire logic              we_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  output logic                   ack_o,
  // comparator inputs
  input  wire logic              supply_uv_i,
  input  wire logic              supply_ov_i,
  input  wire logic              charge_pump_uv_i,
  // analog settings
  output logic      [3:0]        high_side_overcurrent_threshold_o,
  output logic      [3:0]        low_side_overcurrent_threshold_o,
  output logic                   supply_ov_threshold_high_o,
  output logic                   charge_pump_uv_threshold_high_o,
  // offline diagnostics
  output logic                   vds_realtime_mode_o,
  output logic                   offline_diag_enable_o,
  output logic                   bridge1_pullup_source_enable_o,
  output logic                   bridge1_pulldown_source_enable_o,
  output logic                   bridge2_pullup_source_enable_o,
  output logic                   bridge2_pulldown_source_enable_o,
  // protection results
  output logic                   drivers_off_o,
  output logic                   supply_ov_warning_o,
  output logic                   irq_o
);

  // event sources: supply uv, supply ov, ov warning, charge-pump uv
  localparam int NEV = 4;

  // register storage and bus handshake
  logic [7:0]       drain_source_threshold_ctrl_reg;
  logic [7:0]       offline_diag_ctrl_reg;
  logic [7:0]       supply_monitor_ctrl_reg;
  logic [NEV-1:0]   event_status_reg;
  logic [NEV-1:0]   event_mask_reg;
  logic [NEV-1:0]   event_status_next;
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic [7:0]       reg_index;
  logic             wr_stb;
  logic             rd_stb;
  logic             wr_byte0;
  logic             wr_ds;
  logic             wr_diag;
  logic             wr_mon;
  logic             wr_mask;
  logic             wr_status;

  // monitor path
  logic             supply_undervoltage_mode;
  protection_monitor_pkg::ov_mode_t supply_overvoltage_mode;
  logic [1:0]       supply_overvoltage_deglitch;
  logic             charge_pump_undervoltage_mode;
  // overvoltage qualification and handler results
  logic [DG_W-1:0]  ov_limit;
  logic             ov_qualified;
  logic             ov_fault_cond;
  logic             ov_warn_cond;
  logic             uv_fault;
  logic             ov_fault;
  logic             cp_fault;
  logic             any_fault;
  logic [4:0]       monitor_state;

  // event path
  logic [NEV-1:0]   level_now;
  logic [NEV-1:0]   level_prev_reg;
  logic [NEV-1:0]   event_pulse;
  logic [NEV-1:0]   clear_pulse;

  // elaboration checks
  if (ADDR_W < 8) begin : g_bad_addr
    $error("protection_monitor_config: ADDR_W must reach index 8'h12 times four");
  end
  if ((2 ** DG_W) <= `NS_TO_CYC(`OV_DG3_NS)) begin : g_bad_dg
    $error("protection_monitor_config: DG_W too small for the longest deglitch");
  end
  if (`EV_CP_UV >= NEV || `EV_OV_WARN >= NEV) begin : g_bad_nev
    $error("protection_monitor_config: event bit outside the status word");
  end

  // bus decode; sub-word index from the aligned byte address
  // indices beyond one byte fold to 8'hff, so a wide bus never aliases
  assign reg_index = (adr_i[ADDR_W-1:2] <= (ADDR_W-2)'(255)) ?
                     8'(adr_i[ADDR_W-1:2]) : 8'hff;
  // taken only while ack is low, so one access never acts twice
  assign rd_stb    = cyc_i && stb_i && !ack_reg && !we_i;
  assign wr_stb    = cyc_i && stb_i && !ack_reg && we_i;
  assign wr_byte0  = wr_stb && sel_i[0];

  // one write strobe per register; the upper bytes carry nothing
  assign wr_ds     = wr_byte0 && (reg_index == `DS_THRESH_IDX);
  assign wr_diag   = wr_byte0 && (reg_index == `OFFLINE_DIAG_IDX);
  assign wr_mon    = wr_byte0 && (reg_index == `SUPPLY_MON_IDX);
  assign wr_mask   = wr_byte0 && (reg_index == `EVENT_MASK_IDX);
  assign wr_status = wr_byte0 && (reg_index == `EVENT_STATUS_IDX);

  // one-cycle answer for every access, mapped or not
  // ack falls the cycle after it rises; never two in a row
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i && stb_i && !ack_reg;
    end
  end

  assign ack_o = ack_reg;

  // drain-source overcurrent thresholds
  // a write lands at the edge that takes it, the same edge that raises ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drain_source_threshold_ctrl_reg <= `DS_THRESH_RST;
    end else if (wr_ds) begin
      drain_source_threshold_ctrl_reg <= dat_i[7:0];
    end
  end

  // offline diagnostics; reserved bits are plain storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offline_diag_ctrl_reg <= `OFFLINE_DIAG_RST;
    end else if (wr_diag) begin
      offline_diag_ctrl_reg <= dat_i[7:0];
    end
  end

  // supply and charge-pump monitor settings
  // new settings reach the monitors on the next edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_monitor_ctrl_reg <= `SUPPLY_MON_RST;
    end else if (wr_mon) begin
      supply_monitor_ctrl_reg <= dat_i[7:0];
    end
  end

  // interrupt mask, same layout as the status
  // masking only gates irq; the status still records the event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_mask_reg <= `EVENT_MASK_RST;
    end else if (wr_mask) begin
      event_mask_reg <= dat_i[NEV-1:0];
    end
  end

  // field decode
  // the mode enum follows the field codes one to one
  assign supply_undervoltage_mode      = supply_monitor_ctrl_reg[`UV_MODE_BIT];
  assign supply_overvoltage_mode       = protection_monitor_pkg::ov_mode_t'(
                                         supply_monitor_ctrl_reg[`OV_MODE_MSB:`OV_MODE_LSB]);
  assign supply_overvoltage_deglitch   = supply_monitor_ctrl_reg[`OV_DG_MSB:`OV_DG_LSB];
  assign charge_pump_undervoltage_mode = supply_monitor_ctrl_reg[`CP_MODE_BIT];

  // deglitch selection; counts derived from the clock period
  // the width check above keeps the longest count representable
  always_comb begin
    unique case (supply_overvoltage_deglitch)
      2'b00:   ov_limit = DG_W'(`NS_TO_CYC(`OV_DG0_NS));
      2'b01:   ov_limit = DG_W'(`NS_TO_CYC(`OV_DG1_NS));
      2'b10:   ov_limit = DG_W'(`NS_TO_CYC(`OV_DG2_NS));
      2'b11:   ov_limit = DG_W'(`NS_TO_CYC(`OV_DG3_NS));
    endcase
  end

  // any gap in the input restarts the persistence count
  persist_filter #(
    .CNT_W (DG_W)
  ) u_ov_filter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .cond_i      (supply_ov_i),
    .limit_i     (ov_limit),
    .qualified_o (ov_qualified)
  );

  // overvoltage routing by mode
  // warning-only never reaches a handler, so it cannot stop the drivers
  always_comb begin
    ov_fault_cond = 1'b0;
    ov_warn_cond  = 1'b0;
    unique case (supply_overvoltage_mode)
      protection_monitor_pkg::OV_LATCHED:   ov_fault_cond = ov_qualified;
      protection_monitor_pkg::OV_AUTO:      ov_fault_cond = ov_qualified;
      protection_monitor_pkg::OV_WARN_ONLY: ov_warn_cond  = ov_qualified;
      protection_monitor_pkg::OV_DISABLED:  ov_fault_cond = 1'b0;
    endcase
  end

  // software clear of a latched fault is the status write-one
  // it frees a latched handler only once the condition is gone
  assign clear_pulse = wr_status ? dat_i[NEV-1:0] : '0;

  // supply undervoltage acts on the raw level, with no deglitch
  fault_handler u_uv_handler (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cond_i  (supply_uv_i),
    .auto_i  (supply_undervoltage_mode),
    .clear_i (clear_pulse[`EV_SUPPLY_UV]),
    .fault_o (uv_fault)
  );

  // qualified overvoltage; auto recovery only in code 01b
  fault_handler u_ov_handler (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cond_i  (ov_fault_cond),
    .auto_i  (supply_overvoltage_mode == protection_monitor_pkg::OV_AUTO),
    .clear_i (clear_pulse[`EV_SUPPLY_OV]),
    .fault_o (ov_fault)
  );

  // charge-pump undervoltage, raw level like the supply
  fault_handler u_cp_handler (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cond_i  (charge_pump_uv_i),
    .auto_i  (charge_pump_undervoltage_mode),
    .clear_i (clear_pulse[`EV_CP_UV]),
    .fault_o (cp_fault)
  );

  // rising edges of fault and warning levels are the events
  assign level_now = {cp_fault, ov_warn_cond, ov_fault, uv_fault};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_prev_reg <= '0;
    end else begin
      level_prev_reg <= level_now;
    end
  end

  assign event_pulse = level_now & ~level_prev_reg;

  // any active fault; shared by the shutdown and the state word
  assign any_fault     = uv_fault || ov_fault || cp_fault;
  assign monitor_state = {any_fault, level_now};

  // sticky status: set wins over a same-cycle clear
  // write-one-to-clear; bits written as zero are left alone
  assign event_status_next = (event_status_reg & ~clear_pulse) | event_pulse;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_status_reg <= '0;
    end else begin
      event_status_reg <= event_status_next;
    end
  end

  // registered drive of settings and gated diagnostic sources
  // a clock of lag keeps the analog settings free of decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_side_overcurrent_threshold_o <= 4'h0;
      low_side_overcurrent_threshold_o  <= 4'h0;
      supply_ov_threshold_high_o        <= 1'b0;
      charge_pump_uv_threshold_high_o   <= 1'b0;
      vds_realtime_mode_o               <= 1'b0;
      offline_diag_enable_o             <= 1'b0;
      bridge1_pullup_source_enable_o    <= 1'b0;
      bridge1_pulldown_source_enable_o  <= 1'b0;
      bridge2_pullup_source_enable_o    <= 1'b0;
      bridge2_pulldown_source_enable_o  <= 1'b0;
    end else begin
      high_side_overcurrent_threshold_o <=
        drain_source_threshold_ctrl_reg[`HS_THRESH_MSB:`HS_THRESH_LSB];
      low_side_overcurrent_threshold_o  <=
        drain_source_threshold_ctrl_reg[`LS_THRESH_MSB:`LS_THRESH_LSB];
      supply_ov_threshold_high_o        <= supply_monitor_ctrl_reg[`OV_THRESH_BIT];
      charge_pump_uv_threshold_high_o   <= supply_monitor_ctrl_reg[`CP_THRESH_BIT];
      vds_realtime_mode_o               <= offline_diag_ctrl_reg[`DIAG_EN_BIT];
      offline_diag_enable_o             <= offline_diag_ctrl_reg[`DIAG_EN_BIT];
      bridge1_pullup_source_enable_o    <= offline_diag_ctrl_reg[`DIAG_EN_BIT] &&
                                           offline_diag_ctrl_reg[`BR1_PU_BIT];
      bridge1_pulldown_source_enable_o  <= offline_diag_ctrl_reg[`DIAG_EN_BIT] &&
                                           offline_diag_ctrl_reg[`BR1_PD_BIT];
      bridge2_pullup_source_enable_o    <= offline_diag_ctrl_reg[`DIAG_EN_BIT] &&
                                           offline_diag_ctrl_reg[`BR2_PU_BIT];
      bridge2_pulldown_source_enable_o  <= offline_diag_ctrl_reg[`DIAG_EN_BIT] &&
                                           offline_diag_ctrl_reg[`BR2_PD_BIT];
    end
  end

  // fault outputs; a warning never turns the drivers off
  // irq uses the next status so it rises together with the status bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drivers_off_o       <= 1'b0;
      supply_ov_warning_o <= 1'b0;
      irq_o               <= 1'b0;
    end else begin
      drivers_off_o       <= any_fault;
      supply_ov_warning_o <= ov_warn_cond;
      irq_o               <= |(event_status_next & event_mask_reg);
    end
  end

  // read data, captured with the answer; unmapped reads give zero
  // the word stands until the next read is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (rd_stb) begin
      unique case (reg_index)
        `DS_THRESH_IDX:     dat_reg <= {24'h00_0000, drain_source_threshold_ctrl_reg};
        `OFFLINE_DIAG_IDX:  dat_reg <= {24'h00_0000, offline_diag_ctrl_reg};
        `SUPPLY_MON_IDX:    dat_reg <= {24'h00_0000, supply_monitor_ctrl_reg};
        `EVENT_STATUS_IDX:  dat_reg <= {28'h000_0000, event_status_reg};
        `EVENT_MASK_IDX:    dat_reg <= {28'h000_0000, event_mask_reg};
        `MONITOR_STATE_IDX: dat_reg <= {27'h000_0000, monitor_state};
        default:            dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign dat_o = dat_reg;

endmodule : protection_monitor_config

// File: core/protection_monitor_defs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  protection monitor configuration bank. Assumes one 200 MHz clock.
*/
`ifndef PROTECTION_MONITOR_DEFS_SVH
`define PROTECTION_MONITOR_DEFS_SVH

// register indices; byte address is four times the index
`define DS_THRESH_IDX      8'h0a
`define OFFLINE_DIAG_IDX   8'h0b
`define SUPPLY_MON_IDX     8'h0c
`define EVENT_STATUS_IDX   8'h10
`define EVENT_MASK_IDX     8'h11
`define MONITOR_STATE_IDX  8'h12

// reset values
`define DS_THRESH_RST      8'hdd
`define OFFLINE_DIAG_RST   8'h00
`define SUPPLY_MON_RST     8'h14
`define EVENT_MASK_RST     4'h0

// drain-source threshold fields
`define HS_THRESH_MSB      7
`define HS_THRESH_LSB      4
`define LS_THRESH_MSB      3
`define LS_THRESH_LSB      0

// offline diagnostic fields
`define DIAG_EN_BIT        4
`define BR1_PU_BIT         3
`define BR1_PD_BIT         2
`define BR2_PU_BIT         1
`define BR2_PD_BIT         0

// supply monitor fields
`define UV_MODE_BIT        7
`define OV_MODE_MSB        6
`define OV_MODE_LSB        5
`define OV_DG_MSB          4
`define OV_DG_LSB          3
`define OV_THRESH_BIT      2
`define CP_MODE_BIT        1
`define CP_THRESH_BIT      0

// event bits
`define EV_SUPPLY_UV       0
`define EV_SUPPLY_OV       1
`define EV_OV_WARN         2
`define EV_CP_UV           3

// deglitch times and counts
`define CLK_PERIOD_PS      5000
`define OV_DG0_NS          1000
`define OV_DG1_NS          2000
`define OV_DG2_NS          4000
`define OV_DG3_NS          8000
`define NS_TO_CYC(ns)      (((ns) * 1000) / `CLK_PERIOD_PS)

`endif

// File: core/protection_monitor_pkg.sv
/*
  Types shared by the protection monitor bank. No assumptions beyond
  the defs header for numeric constants.
*/
package protection_monitor_pkg;

  // handling of a supply overvoltage event, in field code order
  typedef enum logic [1:0] {
    OV_LATCHED,
    OV_AUTO,
    OV_WARN_ONLY,
    OV_DISABLED
  } ov_mode_t;

  // state of one fault handler
  typedef enum logic {
    MON_CLEAR,
    MON_FAULT
  } mon_state_t;

endpackage : protection_monitor_pkg

// File: core/persist_filter.sv
/*
  Persistence filter: output rises once the condition has held for the
  selected number of cycles. Assumes a synchronous condition input.
*/
`timescale 1ns/100ps
module persist_filter #(
  parameter int CNT_W = 11
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cond_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic                  qualified_o
);

  logic [CNT_W-1:0] count_reg;

  if (CNT_W < 2) begin : g_bad_width
    $error("persist_filter: CNT_W too small");
  end

  // restart on any gap so short glitches never qualify
  always_ff @(posedge clk_i) begin
    if (rst_i || !cond_i) begin
      count_reg <= '0;
    end else if (count_reg < limit_i) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign qualified_o = cond_i && (count_reg >= limit_i);

endmodule : persist_filter

// File: core/fault_handler.sv
/*
  One fault handler: latched or automatic recovery. Assumes clear_i is a
  one-cycle pulse from a software write.
*/
`timescale 1ns/100ps
module fault_handler (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cond_i,
  input  wire logic auto_i,
  input  wire logic clear_i,
  output logic      fault_o
);

  protection_monitor_pkg::mon_state_t state_reg;

  // latched faults wait for software and a gone condition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= protection_monitor_pkg::MON_CLEAR;
    end else begin
      unique case (state_reg)
        protection_monitor_pkg::MON_CLEAR: begin
          if (cond_i) state_reg <= protection_monitor_pkg::MON_FAULT;
        end
        protection_monitor_pkg::MON_FAULT: begin
          if (!cond_i && (auto_i || clear_i)) begin
            state_reg <= protection_monitor_pkg::MON_CLEAR;
          end
        end
      endcase
    end
  end

  assign fault_o = (state_reg == protection_monitor_pkg::MON_FAULT);

endmodule : fault_handler

// File: bench/protection_monitor_config_checker.sv
/*
  Concurrent checks on the protection monitor bank ports.
  Assumes one clock domain and the synchronous active high reset.
*/
`timescale 1ns/100ps
module protection_monitor_config_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       supply_uv_i,
  input wire logic       supply_ov_i,
  input wire logic       charge_pump_uv_i,
  input wire logic [3:0] high_side_overcurrent_threshold_o,
  input wire logic [3:0] low_side_overcurrent_threshold_o,
  input wire logic       supply_ov_threshold_high_o,
  input wire logic       charge_pump_uv_threshold_high_o,
  input wire logic       vds_realtime_mode_o,
  input wire logic       offline_diag_enable_o,
  input wire logic       bridge1_pullup_source_enable_o,
  input wire logic       bridge1_pulldown_source_enable_o,
  input wire logic       bridge2_pullup_source_enable_o,
  input wire logic       bridge2_pulldown_source_enable_o,
  input wire logic       drivers_off_o,
  input wire logic       supply_ov_warning_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // request taken, and the two edge trip path of uv and cp faults
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_trip;
    ##2 drivers_off_o;
  endsequence

  property p_ack_req;
    s_req |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_realtime;
    vds_realtime_mode_o == offline_diag_enable_o;
  endproperty
  property p_br1;
    (bridge1_pullup_source_enable_o || bridge1_pulldown_source_enable_o) |-> offline_diag_enable_o;
  endproperty
  property p_br2;
    (bridge2_pullup_source_enable_o || bridge2_pulldown_source_enable_o) |-> offline_diag_enable_o;
  endproperty
  property p_uv_trip;
    $rose(supply_uv_i) |-> s_trip;
  endproperty
  property p_cp_trip;
    $rose(charge_pump_uv_i) |-> s_trip;
  endproperty
  // a fresh overvoltage raises no warning in its first eight cycles
  property p_ov_min;
    $rose(supply_ov_i) |-> !supply_ov_warning_o [*8];
  endproperty
  property p_reset_vals;
    $fell(rst_i) |=> high_side_overcurrent_threshold_o == 4'hd
      && low_side_overcurrent_threshold_o == 4'hd && supply_ov_threshold_high_o
      && !charge_pump_uv_threshold_high_o;
  endproperty

  a_ack_req: assert property (p_ack_req) else $error("no ack one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_realtime: assert property (p_realtime) else $error("realtime mode differs from enable");
  a_br1: assert property (p_br1) else $error("bridge 1 source without enable");
  a_br2: assert property (p_br2) else $error("bridge 2 source without enable");
  a_uv_trip: assert property (p_uv_trip) else $error("uv did not turn drivers off");
  a_cp_trip: assert property (p_cp_trip) else $error("cp uv did not turn drivers off");
  a_ov_min: assert property (p_ov_min) else $error("ov warning before deglitch");
  a_reset_vals: assert property (p_reset_vals) else $error("wrong settings after reset");
endmodule : protection_monitor_config_checker

bind protection_monitor_config protection_monitor_config_checker u_chk (.clk_i, .rst_i, .cyc_i,
  .stb_i, .ack_o, .supply_uv_i, .supply_ov_i, .charge_pump_uv_i,
  .high_side_overcurrent_threshold_o, .low_side_overcurrent_threshold_o,
  .supply_ov_threshold_high_o, .charge_pump_uv_threshold_high_o, .vds_realtime_mode_o,
  .offline_diag_enable_o, .bridge1_pullup_source_enable_o, .bridge1_pulldown_source_enable_o,
  .bridge2_pullup_source_enable_o, .bridge2_pulldown_source_enable_o, .drivers_off_o,
  .supply_ov_warning_o);

// File: bench/tb_top.sv
/*
  Self-checking bench for the protection monitor bank: Wishbone register
  tasks, fault handling and deglitch sequences. Assumes a 200 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, drv_off, warn, irq, rt, den;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel_i, hs, ls, src;
  logic [2:0] comp;
  logic ovh, cph;
  int failures = 0;
  int checked = 0;

  protection_monitor_config u_protection_monitor_config (.clk_i, .rst_i, .adr_i, .dat_i,
    .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .supply_uv_i(comp[0]),
    .supply_ov_i(comp[1]), .charge_pump_uv_i(comp[2]),
    .high_side_overcurrent_threshold_o(hs), .low_side_overcurrent_threshold_o(ls),
    .supply_ov_threshold_high_o(ovh), .charge_pump_uv_threshold_high_o(cph),
    .vds_realtime_mode_o(rt), .offline_diag_enable_o(den),
    .bridge1_pullup_source_enable_o(src[3]), .bridge1_pulldown_source_enable_o(src[2]),
    .bridge2_pullup_source_enable_o(src[1]), .bridge2_pulldown_source_enable_o(src[0]),
    .drivers_off_o(drv_off), .supply_ov_warning_o(warn), .irq_o(irq));

  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end

  task conclude;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one classic cycle; held until ack is sampled high, then released
  task wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s,
          output logic [31:0] q);
    @(posedge clk_i);
    adr_i <= a; we_i <= w; dat_i <= {24'h0, d}; sel_i <= s; cyc_i <= 1; stb_i <= 1;
    // no limit of its own: the watchdog ends a wait that never answers
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask : wb

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 1, d, 4'hf, q);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    logic [31:0] q;
    wb(a, 0, 8'h00, 4'hf, q);
    chk(nm, q[7:0], exp);
    chk("dat_hi", {7'h0, |q[31:8]}, 8'h00);
  endtask : rd

  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // one fault source: trip, release, then write-one-to-clear its status bit
  task fault(input int i, input logic [7:0] cfg, input logic auto, input int hold);
    logic [7:0] sb;
    sb = (i == 2) ? 8'h08 : 8'(1 << i);
    wr(8'h30, cfg);
    @(posedge clk_i); comp[i] <= 1'b1;
    tick(hold + 4);
    chk("drv_off", {7'h0, drv_off}, 8'h01);
    chk("irq", {7'h0, irq}, 8'h01);
    rd(8'h40, sb, "status");
    rd(8'h48, 8'h10 | sb, "mon_state");
    @(posedge clk_i); comp[i] <= 1'b0;
    tick(4);
    chk("drv_off_rel", {7'h0, drv_off}, {7'h0, !auto});
    wr(8'h40, sb);
    tick(3);
    chk("drv_off_clr", {7'h0, drv_off | irq}, 8'h00);
    rd(8'h40, 8'h00, "status_clr");
  endtask : fault

  initial begin
    logic [31:0] q;
    rst_i <= 1; adr_i <= 0; dat_i <= 0; we_i <= 0;
    sel_i <= 0; cyc_i <= 0; stb_i <= 0; comp <= 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    tick(3);
    chk("out_reset", {hs, ls}, 8'hdd);
    chk("thr_reset", {6'h0, ovh, cph}, 8'h02);
    rd(8'h28, 8'hdd, "ds_reset");
    rd(8'h2c, 8'h00, "diag_reset");
    rd(8'h30, 8'h14, "mon_reset");
    rd(8'h44, 8'h00, "mask_reset");
    // every threshold code, paired high and low
    for (int c = 0; c < 16; c++) begin
      wr(8'h28, {c[3:0], ~c[3:0]});
      tick(2);
      chk("thr_out", {hs, ls}, {c[3:0], ~c[3:0]});
      rd(8'h28, {c[3:0], ~c[3:0]}, "thr_rd");
    end
    // partial byte enables and unmapped places leave state alone
    wb(8'h28, 1, 8'h00, 4'he, q);
    rd(8'h28, 8'hf0, "sel_ignored");
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h00, "unmapped");
    // each source alone, without and with the diagnostic enable
    for (int b = 0; b < 4; b++) begin
      wr(8'h2c, 8'(1 << b));
      tick(2);
      chk("src_off", {3'h0, den, src}, 8'h00);
      wr(8'h2c, 8'hf0 | 8'(1 << b));
      tick(2);
      chk("src_on", {2'h0, rt, den, src}, 8'h30 | 8'(1 << b));
      rd(8'h2c, 8'hf0 | 8'(1 << b), "diag_rd");
    end
    wr(8'h30, 8'hff);
    tick(2);
    chk("thr_hi", {6'h0, ovh, cph}, 8'h03);
    rd(8'h30, 8'hff, "mon_rd");
    wr(8'h30, 8'h00);
    tick(2);
    chk("thr_lo", {6'h0, ovh, cph}, 8'h00);
    wr(8'h44, 8'h0f);
    fault(0, 8'h14, 0, 0);
    fault(0, 8'h94, 1, 0);
    fault(1, 8'h04, 0, 200);
    fault(1, 8'h24, 1, 200);
    fault(2, 8'h14, 0, 0);
    fault(2, 8'h16, 1, 0);
    // warning only, across all four deglitch codes
    for (int d = 0; d < 4; d++) begin
      wr(8'h30, {3'b010, d[1:0], 3'b100});
      @(posedge clk_i); comp[1] <= 1'b1;
      tick((200 << d) - 2);
      chk("warn_early", {7'h0, warn}, 8'h00);
      tick(6);
      chk("warn_on", {6'h0, warn, drv_off}, 8'h02);
      @(posedge clk_i); comp[1] <= 1'b0;
      tick(3);
      chk("warn_off", {7'h0, warn}, 8'h00);
    end
    wr(8'h40, 8'h04);
    // disabled overvoltage monitor ignores the input
    wr(8'h30, 8'h64);
    @(posedge clk_i); comp[1] <= 1'b1;
    tick(210);
    chk("ov_disabled", {6'h0, warn, drv_off}, 8'h00);
    rd(8'h40, 8'h00, "ov_dis_status");
    @(posedge clk_i); comp[1] <= 1'b0;
    // masked event still sets status but keeps irq low
    wr(8'h44, 8'h00);
    wr(8'h30, 8'h94);
    @(posedge clk_i); comp[0] <= 1'b1;
    tick(4);
    chk("irq_masked", {7'h0, irq}, 8'h00);
    rd(8'h40, 8'h01, "masked_status");
    @(posedge clk_i); comp[0] <= 1'b0;
    tick(3);
    conclude();
  end

  // hang guard, far beyond the longest deglitch sequence
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    conclude();
  end
endmodule : tb_top
